// >>> shared/sbakr_pkg.sv
`default_nettype none
package sbakr_pkg;
   // Data and key geometry
   localparam int WORD_W = 32;
   localparam int DIGEST_W = 384;
   localparam int RSA_W = 4096;
   localparam int KEY_W = 256;
   localparam int KEY_WORDS = 8;
   localparam int KEY_IDX_W = 3;
   localparam int KEY_CNT_W = 4;
   // Fuse geometry
   localparam int NUM_AUTH_FUSE = 15;
   localparam int NUM_PPK = 2;
   localparam int NUM_SPK = 32;
   localparam int SECONDARY_KEY_ID_FUSE_REG_W = 5;
   // Block length counter width, in words
   localparam int BLK_LEN_W = 16;
   // Reset values and full key count
   localparam logic [WORD_W-1:0] KEY_WORD_RST = 32'h0000_0000;
   localparam logic [KEY_CNT_W-1:0] KEY_CNT_RST = 4'h0;
   localparam logic [KEY_CNT_W-1:0] KEY_CNT_FULL = 4'h8;
   localparam logic [BLK_LEN_W-1:0] BLK_CNT_RST = 16'h0000;

   // Boot gate states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_AUTH,
      ST_FORWARD,
      ST_KEYWAIT,
      ST_DONE,
      ST_FAIL,
      ST_LOCK,
      ST_BRICK
   } sbakr_state_type;
endpackage
`default_nettype wire

// >>> rtl/sbakr_key_check.sv
`default_nettype none
module sbakr_key_check
   import sbakr_pkg::*;
(
   // Fuse contents
   input wire logic [DIGEST_W-1:0] ppk_digest0_i,
   input wire logic [DIGEST_W-1:0] ppk_digest1_i,
   input wire logic [NUM_PPK-1:0] ppk_revoke_i,
   input wire logic [NUM_SPK-1:0] secondary_key_id_fuse_reg_i,
   // Image header
   input wire logic hdr_ppk_sel_i,
   input wire logic [DIGEST_W-1:0] hdr_ppk_digest_i,
   input wire logic [SECONDARY_KEY_ID_FUSE_REG_W-1:0] hdr_secondary_key_id_fuse_reg_i,
   // Verdict
   output logic key_ok_o,
   output logic all_revoked_o
);
   // Full-width digest equality
   function automatic logic digest_match(input logic [DIGEST_W-1:0] a, input logic [DIGEST_W-1:0] b);
      digest_match = (a == b);
   endfunction

   logic ppk0_ok;
   logic ppk1_ok;
   logic spk_ok;

   // Carried key must match the fuse digest and be unrevoked
   assign ppk0_ok = digest_match(hdr_ppk_digest_i, ppk_digest0_i) && !ppk_revoke_i[0];
   assign ppk1_ok = digest_match(hdr_ppk_digest_i, ppk_digest1_i) && !ppk_revoke_i[1];
   // Secondary key rejected while its id bit is revoked
   assign spk_ok = !secondary_key_id_fuse_reg_i[hdr_secondary_key_id_fuse_reg_i];
   assign key_ok_o = (hdr_ppk_sel_i ? ppk1_ok : ppk0_ok) && spk_ok;
   assign all_revoked_o = &ppk_revoke_i;
endmodule
`default_nettype wire

// >>> rtl/sbakr_key_roll.sv
`default_nettype none
module sbakr_key_roll
   import sbakr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Initial key load
   input wire logic seed_i,
   input wire logic [KEY_W-1:0] seed_key_i,
   // Rolled key words from the decryptor
   input wire logic clr_i,
   input wire logic word_we_i,
   input wire logic [WORD_W-1:0] word_i,
   // Software write port, no read back
   input wire logic sw_we_i,
   input wire logic [KEY_IDX_W-1:0] sw_idx_i,
   input wire logic [WORD_W-1:0] sw_data_i,
   // Key toward decryptor only
   output logic [KEY_W-1:0] key_o,
   output logic full_o
);
   logic [WORD_W-1:0] keys_q [KEY_WORDS];
   logic [WORD_W-1:0] keys_d [KEY_WORDS];
   logic [KEY_CNT_W-1:0] cnt_q;
   logic [KEY_CNT_W-1:0] cnt_d;

   // Next storage contents
   always_comb begin
      keys_d = keys_q;
      cnt_d = cnt_q;
      if (seed_i) begin
         for (int i = 0; i < KEY_WORDS; i++) begin
            keys_d[i] = seed_key_i[i*WORD_W +: WORD_W];
         end
      end else if (clr_i) begin
         cnt_d = KEY_CNT_RST;
      end else if (word_we_i && cnt_q != KEY_CNT_FULL) begin
         keys_d[cnt_q[KEY_IDX_W-1:0]] = word_i;
         cnt_d = cnt_q + 4'h1;
      end else if (sw_we_i) begin
         keys_d[sw_idx_i] = sw_data_i;
      end
   end

   // Eight key update words
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < KEY_WORDS; i++) begin
            keys_q[i] <= KEY_WORD_RST;
         end
         cnt_q <= KEY_CNT_RST;
      end else begin
         keys_q <= keys_d;
         cnt_q <= cnt_d;
      end
   end

   // Flatten for the decryptor
   always_comb begin
      key_o = '0;
      for (int i = 0; i < KEY_WORDS; i++) begin
         key_o[i*WORD_W +: WORD_W] = keys_q[i];
      end
   end
   assign full_o = (cnt_q == KEY_CNT_FULL);
endmodule
`default_nettype wire

// >>> rtl/sbakr_boot_gate.sv
`default_nettype none
module sbakr_boot_gate
   import sbakr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fuse array
   input wire logic [NUM_AUTH_FUSE-1:0] auth_en_fuse_i,
   input wire logic secure_lockdown_fuse_i,
   input wire logic [DIGEST_W-1:0] ppk_digest0_i,
   input wire logic [DIGEST_W-1:0] ppk_digest1_i,
   input wire logic [NUM_PPK-1:0] ppk_revoke_i,
   input wire logic [NUM_SPK-1:0] secondary_key_id_fuse_reg_i,
   // Key 0 sources
   input wire logic key_src_battery_backed_key_store_i,
   input wire logic [KEY_W-1:0] key0_fuse_i,
   input wire logic [KEY_W-1:0] key0_battery_backed_key_store_i,
   // Image header
   input wire logic hdr_valid_i,
   input wire logic hdr_ppk_sel_i,
   input wire logic [DIGEST_W-1:0] hdr_ppk_digest_i,
   input wire logic [SECONDARY_KEY_ID_FUSE_REG_W-1:0] hdr_secondary_key_id_fuse_reg_i,
   input wire logic [BLK_LEN_W-1:0] blk_len_i,
   // Signature engine
   output logic sig_start_o,
   input wire logic sig_done_i,
   input wire logic sig_ok_i,
   // Image stream, second pass
   input wire logic img_valid_i,
   input wire logic [WORD_W-1:0] img_data_i,
   input wire logic img_last_i,
   output logic img_ready_o,
   // Decryptor data
   output logic dec_valid_o,
   output logic [WORD_W-1:0] dec_data_o,
   output logic dec_last_o,
   input wire logic dec_ready_i,
   // Decryptor key
   output logic dec_enable_o,
   output logic dec_key_load_o,
   output logic [KEY_W-1:0] dec_key_o,
   input wire logic dec_key_valid_i,
   input wire logic [WORD_W-1:0] dec_key_word_i,
   // Software key update write port
   input wire logic sw_key_we_i,
   input wire logic [KEY_IDX_W-1:0] sw_key_idx_i,
   input wire logic [WORD_W-1:0] sw_key_data_i,
   // Status
   output logic auth_required_o,
   output logic boot_done_o,
   output logic auth_fail_o,
   output logic lockdown_o,
   output logic bricked_o
);
   sbakr_state_type state_q;
   sbakr_state_type state_d;
   logic [BLK_LEN_W-1:0] cnt_q;
   logic [BLK_LEN_W-1:0] cnt_d;
   logic dec_valid_q;
   logic dec_valid_d;
   logic [WORD_W-1:0] dec_data_q;
   logic [WORD_W-1:0] dec_data_d;
   logic dec_last_q;
   logic dec_last_d;
   logic sig_start_q;
   logic sig_start_d;
   logic key_load_q;
   logic key_load_d;
   logic fail_q;
   logic fail_d;

   logic auth_req;
   logic key_ok;
   logic all_revoked;
   logic seed;
   logic roll_clr;
   logic roll_full;
   logic take;
   logic blk_end;
   logic out_free;

   // Where a failed authentication leads
   function automatic sbakr_state_type fail_dest(input logic lock_fuse);
      fail_dest = lock_fuse ? ST_LOCK : ST_FAIL;
   endfunction

   // Primary and secondary key screening
   sbakr_key_check u_check (
      .ppk_digest0_i(ppk_digest0_i),
      .ppk_digest1_i(ppk_digest1_i),
      .ppk_revoke_i(ppk_revoke_i),
      .secondary_key_id_fuse_reg_i(secondary_key_id_fuse_reg_i),
      .hdr_ppk_sel_i(hdr_ppk_sel_i),
      .hdr_ppk_digest_i(hdr_ppk_digest_i),
      .hdr_secondary_key_id_fuse_reg_i(hdr_secondary_key_id_fuse_reg_i),
      .key_ok_o(key_ok),
      .all_revoked_o(all_revoked)
   );

   // Key update storage
   sbakr_key_roll u_roll (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .seed_i(seed),
      .seed_key_i(key_src_battery_backed_key_store_i ? key0_battery_backed_key_store_i : key0_fuse_i),
      .clr_i(roll_clr),
      .word_we_i(state_q == ST_KEYWAIT && dec_key_valid_i),
      .word_i(dec_key_word_i),
      .sw_we_i(sw_key_we_i && state_q == ST_DONE),
      .sw_idx_i(sw_key_idx_i),
      .sw_data_i(sw_key_data_i),
      .key_o(dec_key_o),
      .full_o(roll_full)
   );

   // Any single enable fuse forces authentication
   assign auth_req = |auth_en_fuse_i;

   // Stream handshake terms
   assign out_free = !dec_valid_q || dec_ready_i;
   assign img_ready_o = (state_q == ST_FORWARD) && out_free;
   assign take = img_valid_i && img_ready_o;
   assign blk_end = ({1'b0, cnt_q} + 17'h0_0001) >= {1'b0, blk_len_i};

   // Key 0 loads as forwarding starts; counter clears on each roll
   assign seed = (state_q != ST_FORWARD) && (state_d == ST_FORWARD) && (state_q != ST_KEYWAIT);
   assign roll_clr = (state_q == ST_FORWARD) && (state_d == ST_KEYWAIT);

   // Boot gate sequencing
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      sig_start_d = 1'b0;
      key_load_d = 1'b0;
      fail_d = fail_q;
      case (state_q)
         ST_IDLE: begin
            if (hdr_valid_i) begin
               fail_d = 1'b0;
               cnt_d = BLK_CNT_RST;
               if (!auth_req) begin
                  state_d = ST_FORWARD;
                  key_load_d = 1'b1;
               end else if (all_revoked) begin
                  state_d = ST_BRICK;
               end else if (!key_ok) begin
                  fail_d = 1'b1;
                  state_d = fail_dest(secure_lockdown_fuse_i);
               end else begin
                  state_d = ST_AUTH;
                  sig_start_d = 1'b1;
               end
            end
         end
         ST_AUTH: begin
            if (sig_done_i) begin
               if (sig_ok_i) begin
                  state_d = ST_FORWARD;
                  key_load_d = 1'b1;
               end else begin
                  fail_d = 1'b1;
                  state_d = fail_dest(secure_lockdown_fuse_i);
               end
            end
         end
         ST_FORWARD: begin
            if (take) begin
               if (img_last_i) begin
                  state_d = ST_DONE;
               end else if (blk_end) begin
                  state_d = ST_KEYWAIT;
                  cnt_d = BLK_CNT_RST;
               end else begin
                  cnt_d = cnt_q + 16'h0001;
               end
            end
         end
         ST_KEYWAIT: begin
            if (roll_full) begin
               state_d = ST_FORWARD;
               key_load_d = 1'b1;
            end
         end
         ST_FAIL: begin
            // New image may be offered; no key is cleared
            if (!hdr_valid_i) begin
               state_d = ST_IDLE;
            end
         end
         ST_DONE, ST_LOCK, ST_BRICK: begin
            state_d = state_q;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Output word register toward the decryptor
   always_comb begin
      dec_valid_d = dec_valid_q;
      dec_data_d = dec_data_q;
      dec_last_d = dec_last_q;
      if (take) begin
         dec_valid_d = 1'b1;
         dec_data_d = img_data_i;
         dec_last_d = img_last_i;
      end else if (dec_ready_i) begin
         dec_valid_d = 1'b0;
      end
   end

   // State registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q <= BLK_CNT_RST;
         dec_valid_q <= 1'b0;
         dec_data_q <= KEY_WORD_RST;
         dec_last_q <= 1'b0;
         sig_start_q <= 1'b0;
         key_load_q <= 1'b0;
         fail_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         dec_valid_q <= dec_valid_d;
         dec_data_q <= dec_data_d;
         dec_last_q <= dec_last_d;
         sig_start_q <= sig_start_d;
         key_load_q <= key_load_d;
         fail_q <= fail_d;
      end
   end

   // Outputs
   assign sig_start_o = sig_start_q;
   assign dec_valid_o = dec_valid_q;
   assign dec_data_o = dec_data_q;
   assign dec_last_o = dec_last_q;
   assign dec_key_load_o = key_load_q;
   // Decryptor live only on accepted images
   assign dec_enable_o = (state_q == ST_FORWARD) || (state_q == ST_KEYWAIT) ||
                         (state_q == ST_DONE) || dec_valid_q;
   assign auth_required_o = auth_req;
   assign boot_done_o = (state_q == ST_DONE);
   assign auth_fail_o = fail_q;
   assign lockdown_o = (state_q == ST_LOCK);
   assign bricked_o = (state_q == ST_BRICK);
endmodule
`default_nettype wire

// >>> tb/sbakr_chk.sv
`default_nettype none
module sbakr_chk
   import sbakr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fuses
   input wire logic [NUM_AUTH_FUSE-1:0] auth_en_fuse_i,
   input wire logic secure_lockdown_fuse_i,
   input wire logic [NUM_PPK-1:0] ppk_revoke_i,
   // Streams
   input wire logic img_ready_o,
   input wire logic dec_valid_o,
   input wire logic [WORD_W-1:0] dec_data_o,
   input wire logic dec_ready_i,
   // Control and status
   input wire logic sig_start_o,
   input wire logic dec_enable_o,
   input wire logic dec_key_load_o,
   input wire logic auth_required_o,
   input wire logic boot_done_o,
   input wire logic auth_fail_o,
   input wire logic lockdown_o,
   input wire logic bricked_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Gate behaviour
   a_fwd_needs_enable: assert property (dec_valid_o |-> dec_enable_o)
      else $error("decryptor data while disabled");
   a_ready_in_forward: assert property (img_ready_o |-> dec_enable_o && !boot_done_o)
      else $error("image taken outside forwarding");
   a_fail_blocks_dec: assert property (auth_fail_o |-> !dec_enable_o && !dec_valid_o)
      else $error("decryptor active after failure");
   a_lock_cause: assert property ($rose(lockdown_o) |-> secure_lockdown_fuse_i && auth_fail_o)
      else $error("lockdown without fuse or failure");
   a_auth_any_fuse: assert property (auth_required_o == (|auth_en_fuse_i))
      else $error("auth requirement not OR of fuses");
   a_sig_one_pulse: assert property (sig_start_o |-> auth_required_o ##1 !sig_start_o)
      else $error("bad signature start pulse");
   a_brick_cause: assert property (bricked_o |-> (&ppk_revoke_i) && auth_required_o)
      else $error("brick without both revocations");
   a_out_holds: assert property (dec_valid_o && !dec_ready_i |=> dec_valid_o && $stable(dec_data_o))
      else $error("output word dropped under stall");
   a_load_pulse: assert property (dec_key_load_o |=> !dec_key_load_o)
      else $error("key load longer than a cycle");
   a_done_sticky: assert property (boot_done_o |=> boot_done_o && dec_enable_o)
      else $error("done state left");
endmodule
bind sbakr_boot_gate sbakr_chk u_chk (.*);
`default_nettype wire

// >>> tb/sbakr_dec_model.sv
`default_nettype none
module sbakr_dec_model
   import sbakr_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bench control
   input wire logic verdict_i,
   input wire logic stall_i,
   input wire logic [WORD_W-1:0] key_base_i,
   input wire logic [BLK_LEN_W-1:0] blk_len_i,
   // Signature engine
   input wire logic start_i,
   output logic done_o,
   output logic ok_o,
   // Decryptor
   input wire logic dvalid_i,
   input wire logic dlast_i,
   output logic ready_o,
   output logic kvalid_o,
   output logic [WORD_W-1:0] kword_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;
   logic [3:0] kcnt_q;
   logic [BLK_LEN_W-1:0] wcnt_q;
   logic tog_q;
   // Verdict three cycles after start, junk otherwise
   assign done_o = (wait_q == 4'h1);
   assign ok_o = done_o ? verdict_i : ~verdict_i;
   // Stall every other cycle on request
   assign ready_o = !(stall_i && tog_q);
   // Unwrapped key words, word 0 first, inverted filler when idle
   assign kvalid_o = (kcnt_q != 4'h0);
   assign kword_o = kvalid_o ? key_base_i + 32'(KEY_WORDS - kcnt_q) : ~key_base_i;
   // Counters for verdict delay, block words and key words
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= 4'h0;
         kcnt_q <= 4'h0;
         wcnt_q <= BLK_CNT_RST;
         tog_q <= 1'b0;
      end else begin
         tog_q <= !tog_q;
         if (start_i) begin
            wait_q <= 4'h3;
         end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end
         if (kvalid_o) begin
            kcnt_q <= kcnt_q - 4'h1;
         end
         if (dvalid_i && ready_o) begin
            wcnt_q <= wcnt_q + 16'h0001;
            if (wcnt_q + 16'h0001 >= blk_len_i && !dlast_i) begin
               wcnt_q <= BLK_CNT_RST;
               kcnt_q <= 4'h8;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
module tb_top
   import sbakr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [KEY_W-1:0] K0F = {8{32'h1111_2222}};
   localparam logic [KEY_W-1:0] KBB = {8{32'h3333_4444}};
   localparam logic [DIGEST_W-1:0] DG0 = {12{32'hA5A5_0F0F}};
   localparam logic [DIGEST_W-1:0] DG1 = {12{32'h1234_5678}};
   localparam logic [WORD_W-1:0] KB = 32'hC000_0000;
   localparam logic [WORD_W-1:0] WB = 32'hD000_0000;
   logic clk_i = 1'b0, rst_i = 1'b1, secure_lockdown_fuse_i = 1'b0, key_src_battery_backed_key_store_i = 1'b0;
   logic [NUM_AUTH_FUSE-1:0] auth_en_fuse_i = '0;
   logic [DIGEST_W-1:0] ppk_digest0_i = DG0, ppk_digest1_i = DG1, hdr_ppk_digest_i = '0;
   logic [NUM_PPK-1:0] ppk_revoke_i = '0;
   logic [NUM_SPK-1:0] secondary_key_id_fuse_reg_i = '0;
   logic [KEY_W-1:0] key0_fuse_i = K0F, key0_battery_backed_key_store_i = KBB, dec_key_o;
   logic hdr_valid_i = 1'b0, hdr_ppk_sel_i = 1'b0, img_valid_i = 1'b0, img_last_i = 1'b0;
   logic [SECONDARY_KEY_ID_FUSE_REG_W-1:0] hdr_secondary_key_id_fuse_reg_i = '0;
   logic [BLK_LEN_W-1:0] blk_len_i = 16'h0010;
   logic [WORD_W-1:0] img_data_i = '0, sw_key_data_i = '0, dec_key_word_i, dec_data_o;
   logic sw_key_we_i = 1'b0, verdict = 1'b0, stall = 1'b0;
   logic [KEY_IDX_W-1:0] sw_key_idx_i = '0;
   logic sig_start_o, sig_done_i, sig_ok_i, img_ready_o, dec_valid_o, dec_last_o, dec_ready_i;
   logic dec_enable_o, dec_key_load_o, dec_key_valid_i, auth_required_o, boot_done_o;
   logic auth_fail_o, lockdown_o, bricked_o;
   logic [WORD_W-1:0] got[$], exp_q[$];
   int fail_count = 0, check_count = 0, cyc = 0, loads = 0, lasts = 0;

   sbakr_boot_gate dut (.*);
   sbakr_dec_model u_far (.clk_i(clk_i), .rst_i(rst_i), .verdict_i(verdict), .stall_i(stall),
      .key_base_i(KB), .blk_len_i(blk_len_i), .start_i(sig_start_o), .done_o(sig_done_i),
      .ok_o(sig_ok_i), .dvalid_i(dec_valid_o), .dlast_i(dec_last_o), .ready_o(dec_ready_i),
      .kvalid_o(dec_key_valid_i), .kword_o(dec_key_word_i));

   // Clock
   always #2.5 clk_i = ~clk_i;
   // Output capture on settled values, transfer completes at the next rising edge
   always @(negedge clk_i) begin
      if (dec_valid_o === 1'b1 && dec_ready_i === 1'b1) begin
         got.push_back(dec_data_o);
         if (dec_last_o === 1'b1)
            lasts++;
      end
      if (dec_key_load_o === 1'b1)
         loads++;
   end

   task automatic check(input logic [KEY_W-1:0] seen, input logic [KEY_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // Present one header and wait for the verdict
   task automatic boot(input logic sel, input logic dg, input logic vd, input logic [SECONDARY_KEY_ID_FUSE_REG_W-1:0] id);
      repeat (2) @(posedge clk_i);
      hdr_ppk_sel_i <= sel;
      hdr_ppk_digest_i <= !dg ? ~DG0 : (sel ? DG1 : DG0);
      hdr_secondary_key_id_fuse_reg_i <= id;
      verdict <= vd;
      hdr_valid_i <= 1'b1;
      @(posedge clk_i);
      repeat (20) begin
         @(negedge clk_i);
         if (dec_enable_o | auth_fail_o | lockdown_o | bricked_o)
            break;
      end
      @(posedge clk_i);
      hdr_valid_i <= 1'b0;
   endtask

   // Offer n words; each is held until ready is seen high before the taking edge
   task automatic send(input int n);
      int b = got.size();
      for (int i = 0; i < n; i++) begin
         img_valid_i <= 1'b1;
         img_data_i <= WB + i;
         img_last_i <= (i == n - 1);
         exp_q.push_back(WB + i);
         @(negedge clk_i);
         while (img_ready_o !== 1'b1)
            @(negedge clk_i);
         @(posedge clk_i);
      end
      img_valid_i <= 1'b0;
      img_last_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      check(got.size() - b, exp_q.size());
      foreach (exp_q[i])
         check(got[b + i], exp_q[i]);
      check(boot_done_o, 1'b1);
      exp_q = {};
   endtask

   task automatic t_unsigned;
      boot(1'b0, 1'b0, 1'b0, 5'h00);
      check({auth_required_o, dec_enable_o, auth_fail_o}, 3'h2);
      repeat (3) @(posedge clk_i);
      check(dec_key_o, K0F);
      send(3);
      check(loads, 1);
      check(lasts, 1);
      sw_key_we_i <= 1'b1;
      sw_key_idx_i <= 3'h7;
      sw_key_data_i <= 32'hFFFF_0000;
      @(posedge clk_i);
      sw_key_we_i <= 1'b0;
      @(posedge clk_i);
      check(boot_done_o, 1'b1);
      check(dec_key_o, {32'hFFFF_0000, K0F[KEY_W-WORD_W-1:0]});
   endtask

   task automatic t_roll;
      logic [KEY_W-1:0] k;
      for (int i = 0; i < KEY_WORDS; i++)
         k[i*WORD_W +: WORD_W] = KB + i;
      auth_en_fuse_i <= 15'h4000;
      key_src_battery_backed_key_store_i <= 1'b1;
      blk_len_i <= 16'h0002;
      stall <= 1'b1;
      do_reset();
      boot(1'b1, 1'b1, 1'b1, 5'h1F);
      check({auth_required_o, dec_enable_o}, 2'h3);
      repeat (3) @(posedge clk_i);
      check(dec_key_o, KBB);
      send(4);
      check(dec_key_o, k);
      check(loads, 3);
      check(lasts, 2);
      stall <= 1'b0;
   endtask

   task automatic t_reject;
      auth_en_fuse_i <= 15'h0001;
      key_src_battery_backed_key_store_i <= 1'b0;
      do_reset();
      boot(1'b0, 1'b1, 1'b0, 5'h00);
      check({auth_fail_o, dec_enable_o, lockdown_o, boot_done_o}, 4'h8);
      boot(1'b1, 1'b0, 1'b1, 5'h00);
      check({auth_fail_o, dec_enable_o}, 2'h2);
      ppk_revoke_i <= 2'h1;
      secondary_key_id_fuse_reg_i <= 32'h8000_0000;
      boot(1'b0, 1'b1, 1'b1, 5'h07);
      check({auth_fail_o, dec_enable_o}, 2'h2);
      boot(1'b1, 1'b1, 1'b1, 5'h1F);
      check({auth_fail_o, dec_enable_o}, 2'h2);
      boot(1'b1, 1'b1, 1'b1, 5'h07);
      check({auth_fail_o, dec_enable_o, bricked_o}, 3'h2);
      repeat (3) @(posedge clk_i);
      check(dec_key_o, K0F);
   endtask

   task automatic t_penalty;
      auth_en_fuse_i <= 15'h0020;
      secure_lockdown_fuse_i <= 1'b1;
      ppk_revoke_i <= 2'h0;
      do_reset();
      boot(1'b0, 1'b1, 1'b0, 5'h00);
      check({lockdown_o, dec_enable_o, boot_done_o}, 3'h4);
      ppk_revoke_i <= 2'h3;
      do_reset();
      boot(1'b1, 1'b1, 1'b1, 5'h00);
      check({bricked_o, dec_enable_o, boot_done_o}, 3'h4);
   endtask

   // Main sequence against a cycle ceiling
   initial begin
      fork
         begin
            do_reset();
            t_unsigned();
            t_roll();
            t_reject();
            t_penalty();
         end
         begin
            while (cyc < 20000) begin
               @(posedge clk_i);
               cyc++;
            end
            fail_count++;
         end
      join_any
      summarize();
   end
endmodule
`default_nettype wire
